/* shared/cmp_cfg_if.sv */
// Settings of one comparator passed to its channel logic
interface cmp_cfg_if;
    logic enable;
    logic [1:0] hyst_pos;
    logic [1:0] hyst_neg;
    logic [1:0] mode;
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
    logic rise_ie;
    logic fall_ie;
    logic clr_rise;
    logic clr_fall;
    logic rise_flag;
    logic fall_flag;
    logic out_state;
    logic latched_out;
    logic irq;
    modport regs (output enable, hyst_pos, hyst_neg, mode, pos_sel,
        neg_sel, rise_ie, fall_ie, clr_rise, clr_fall,
        input rise_flag, fall_flag, out_state, latched_out, irq);
    modport chan (input enable, hyst_pos, hyst_neg, mode, pos_sel,
        neg_sel, rise_ie, fall_ie, clr_rise, clr_fall,
        output rise_flag, fall_flag, out_state, latched_out, irq);
endinterface

/* shared/cmp_pkg.sv */
// How it works
// - First negative select: pins, ground, none
// - Second positive select: pins, regulator, none
// - Second negative select: pins, ground, none
// - Latched and raw outputs per comparator
// - Raw output needs no clock
// - Disabled: outputs low, power off
// - Software selects response time mode
// - Negative hysteresis field drives analog
// - Positive hysteresis field independent, same way
// - Falling output edge sets falling flag
// - Rising output edge sets rising flag
// - Flags sticky until software clears
// - Rising enable gates rising flag request
// - Falling enable gates falling flag request
// - Output state bit read only, live
// - Enable bit switches comparator on/off
// - Hysteresis codes: off, 5, 10, 20 mV
// - Mode 00 fastest to 11 slowest, reset 10
// - First positive select: pins, regulator, none
// - Latch output at counter array overflow into mode bit 7; LATCHED_OUTPUT pin is the synchronized output
package cmp_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL0_ADDR = 8'h00;
    localparam logic [7:0] MODE0_ADDR = 8'h04;
    localparam logic [7:0] MUX0_ADDR = 8'h08;
    localparam logic [7:0] CTRL1_ADDR = 8'h0C;
    localparam logic [7:0] MODE1_ADDR = 8'h10;
    localparam logic [7:0] MUX1_ADDR = 8'h14;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int EN_BIT = 7;
    localparam int OUT_BIT = 6;
    localparam int RISE_BIT = 5;
    localparam int FALL_BIT = 4;
    localparam int HYP_LSB = 2;
    localparam int HYN_LSB = 0;
    localparam int LOUT_BIT = 7;
    localparam int RIE_BIT = 5;
    localparam int FIE_BIT = 4;
    localparam int MD_LSB = 0;
    localparam int MXN_LSB = 4;
    localparam int MXP_LSB = 0;
    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_RESET = 2'h2;
    localparam logic [3:0] MUX_RESET = 4'hF;
    localparam logic [3:0] MUX_PIN_MAX = 4'h7;
    localparam logic [3:0] MUX_INTERNAL = 4'h8;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

/* verif/dual_comparator_control_chk.sv */
module dual_comparator_control_chk (
    // System
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // Read handshake
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    // Comparator side
    input wire logic [1:0] ANALOG_OUT,
    input wire logic [1:0] POWER_ON,
    input wire logic [8:0] POS_ROUTE0,
    input wire logic [8:0] NEG_ROUTE0,
    input wire logic [8:0] POS_ROUTE1,
    input wire logic [8:0] NEG_ROUTE1,
    input wire logic [3:0] RESPONSE_MODE,
    input wire logic [1:0] LATCHED_OUTPUT,
    input wire logic [1:0] RAW_OUTPUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_B);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    raw_gate_a: assert property (
        RAW_OUTPUT == (POWER_ON & ANALOG_OUT)) else $error("raw output");
    latched_off_a: assert property (
        (LATCHED_OUTPUT & ~POWER_ON) == 2'h0) else $error("latched on");
    // Four samples cover the two sync stages with one cycle to spare
    first_high_a: assert property (
        (POWER_ON[0] && ANALOG_OUT[0])[*4] |-> LATCHED_OUTPUT[0])
        else $error("first latched output stuck low");
    first_low_a: assert property (
        (!ANALOG_OUT[0])[*4] |-> !LATCHED_OUTPUT[0])
        else $error("first latched output stuck high");
    second_high_a: assert property (
        (POWER_ON[1] && ANALOG_OUT[1])[*4] |-> LATCHED_OUTPUT[1])
        else $error("second latched output stuck low");
    route_onehot_a: assert property (
        $onehot0(POS_ROUTE0) && $onehot0(NEG_ROUTE0) &&
        $onehot0(POS_ROUTE1) && $onehot0(NEG_ROUTE1))
        else $error("route not one-hot");
    mode_reset_a: assert property (
        $rose(RST_B) |-> RESPONSE_MODE == 4'hA) else $error("mode reset");
    read_answer_a: assert property (
        ARVALID && ARREADY |=> RVALID) else $error("read answer late");
endmodule

bind dual_comparator_control dual_comparator_control_chk u_chk (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RVALID(RVALID), .ANALOG_OUT(ANALOG_OUT),
    .POWER_ON(POWER_ON), .POS_ROUTE0(POS_ROUTE0),
    .NEG_ROUTE0(NEG_ROUTE0), .POS_ROUTE1(POS_ROUTE1),
    .NEG_ROUTE1(NEG_ROUTE1), .RESPONSE_MODE(RESPONSE_MODE),
    .LATCHED_OUTPUT(LATCHED_OUTPUT), .RAW_OUTPUT(RAW_OUTPUT)
);

/* verif/dual_comparator_control_tb.sv */
`define CHK(g, e) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("[ERR] %0t got %h exp %h", $time, g, e); \
    end \
end

module dual_comparator_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic ovf = 1'h0;
    logic [1:0] ana = 2'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp, pwr, lat, raw, irq;
    logic [8:0] pr0, nr0, pr1, nr1;
    logic [3:0] hp, hn, md;
    logic [31:0] rdata, rd_q;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    dual_comparator_control u_dut (
        .CORE_CLK(clk), .RST_B(rst_b),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .ANALOG_OUT(ana), .COUNTER_OVERFLOW(ovf), .POWER_ON(pwr),
        .POS_ROUTE0(pr0), .NEG_ROUTE0(nr0),
        .POS_ROUTE1(pr1), .NEG_ROUTE1(nr1),
        .HYST_POS(hp), .HYST_NEG(hn), .RESPONSE_MODE(md),
        .LATCHED_OUTPUT(lat), .RAW_OUTPUT(raw), .CMP_IRQ(irq)
    );

    always #20 clk = ~clk;

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Bus tasks and helpers
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rd_q = rdata;
        resp = rresp;
        rready <= 1'h0;
        `CHK(rd_q, {24'h000000, e})
    endtask

    function automatic logic [8:0] rt(input logic [3:0] c);
        if (c <= 4'h8) return 9'h001 << c;
        return 9'h000;
    endfunction

    task automatic pulse;
        ovf <= 1'h1;
        @(posedge clk);
        ovf <= 1'h0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(cmp_pkg::CTRL0_ADDR, 8'h00);
        rd(cmp_pkg::MODE1_ADDR, 8'h02);
        rd(cmp_pkg::MUX0_ADDR, 8'hFF);
        `CHK(md, 4'hA)
        `CHK({pwr, pr1, nr1}, 20'h00000)
        wr(8'h18, 8'hFF);
        `CHK(resp, cmp_pkg::AXI_SLVERR)
        rd(8'h18, 8'h00);
        `CHK(resp, cmp_pkg::AXI_SLVERR)
        rd(cmp_pkg::MUX1_ADDR, 8'hFF);
        // Without byte lane 0 a write must leave the register alone
        wstrb <= 4'hE;
        wr(cmp_pkg::MUX1_ADDR, 8'h00);
        `CHK(resp, cmp_pkg::AXI_OKAY)
        wstrb <= 4'hF;
        rd(cmp_pkg::MUX1_ADDR, 8'hFF);
        $display("reset test done");
    endtask

    task automatic t_mux;
        logic [3:0] c;
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            wr(cmp_pkg::MUX0_ADDR, {c, ~c});
            wr(cmp_pkg::MUX1_ADDR, {~c, c});
            `CHK(nr0, rt(c))
            `CHK(pr0, rt(~c))
            `CHK(pr1, rt(c))
            `CHK(nr1, rt(~c))
        end
        $display("mux test done");
    endtask

    task automatic t_cfg;
        logic [1:0] v;
        for (int i = 0; i < 4; i++) begin
            v = 2'(i);
            wr(cmp_pkg::CTRL0_ADDR, {4'h0, v, ~v});
            wr(cmp_pkg::CTRL1_ADDR, {4'h0, ~v, v});
            wr(cmp_pkg::MODE0_ADDR, {6'h00, v});
            wr(cmp_pkg::MODE1_ADDR, {6'h00, ~v});
            `CHK(hp, {~v, v})
            `CHK(hn, {v, ~v})
            `CHK(md, {~v, v})
            rd(cmp_pkg::CTRL0_ADDR, {4'h0, v, ~v});
        end
        $display("config test done");
    endtask

    task automatic t_edge;
        wr(cmp_pkg::CTRL0_ADDR, 8'hB0);
        // Stale edges from power-up are wiped before relying on flags
        wr(cmp_pkg::CTRL0_ADDR, 8'h80);
        `CHK(pwr[0], 1'h1)
        ana[0] <= 1'h1;
        repeat (5) @(posedge clk);
        `CHK({raw[0], lat[0]}, 2'h3)
        rd(cmp_pkg::CTRL0_ADDR, 8'hE0);
        `CHK(irq[0], 1'h0)
        wr(cmp_pkg::MODE0_ADDR, 8'h22);
        `CHK(irq[0], 1'h1)
        ana[0] <= 1'h0;
        repeat (5) @(posedge clk);
        rd(cmp_pkg::CTRL0_ADDR, 8'hB0);
        wr(cmp_pkg::MODE0_ADDR, 8'h12);
        `CHK(irq[0], 1'h1)
        wr(cmp_pkg::CTRL0_ADDR, 8'hE0);
        rd(cmp_pkg::CTRL0_ADDR, 8'hA0);
        `CHK(irq[0], 1'h0)
        $display("edge test done");
    endtask

    task automatic t_dis;
        ana[0] <= 1'h1;
        repeat (4) @(posedge clk);
        wr(cmp_pkg::CTRL0_ADDR, 8'h30);
        `CHK(pwr[0], 1'h0)
        `CHK({raw[0], lat[0]}, 2'h0)
        wr(cmp_pkg::CTRL1_ADDR, 8'h80);
        ana[1] <= 1'h1;
        // Raw path answers between edges, latched one cannot yet
        #5;
        `CHK({raw[1], lat[1]}, 2'h2)
        repeat (4) @(posedge clk);
        rd(cmp_pkg::CTRL1_ADDR, 8'hE0);
        wr(cmp_pkg::MODE1_ADDR, 8'h22);
        `CHK(irq[1], 1'h1)
        wr(cmp_pkg::MODE1_ADDR, 8'h02);
        `CHK(irq[1], 1'h0)
        $display("disable test done");
    endtask

    task automatic t_ovf;
        wr(cmp_pkg::CTRL0_ADDR, 8'h80);
        repeat (4) @(posedge clk);
        pulse();
        rd(cmp_pkg::MODE0_ADDR, 8'h92);
        ana[0] <= 1'h0;
        repeat (4) @(posedge clk);
        rd(cmp_pkg::MODE0_ADDR, 8'h92);
        pulse();
        rd(cmp_pkg::MODE0_ADDR, 8'h12);
        $display("overflow test done");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        t_reset();
        t_mux();
        t_cfg();
        t_edge();
        t_dis();
        t_ovf();
        summarize();
    end
endmodule

/* verilog/cmp_channel.sv */
module cmp_channel (
    // System
    input wire logic clk,
    input wire logic rst_b,
    // Settings and status
    cmp_cfg_if.chan cfg,
    // Analog side
    input wire logic analog_out,
    input wire logic overflow,
    output logic power_on,
    output logic [8:0] pos_route,
    output logic [8:0] neg_route,
    output logic [1:0] hyst_pos,
    output logic [1:0] hyst_neg,
    output logic [1:0] mode,
    // Pins
    output logic sync_out,
    output logic raw_out
);
    logic meta;
    logic sync;
    logic sync_d;
    logic rise;
    logic fall;
    logic rise_flag;
    logic fall_flag;
    logic latched;

    // One-hot routing; codes above the internal source connect nothing
    function automatic logic [8:0] route(input logic [3:0] sel);
        route = (sel <= cmp_pkg::MUX_INTERNAL) ? 9'(9'h001 << sel) : 9'h000;
    endfunction

    assign power_on = cfg.enable;
    assign pos_route = route(cfg.pos_sel);
    assign neg_route = route(cfg.neg_sel);
    assign hyst_pos = cfg.hyst_pos;
    assign hyst_neg = cfg.hyst_neg;
    assign mode = cfg.mode;
    // No clock in this path, so it keeps working in stop mode
    assign raw_out = cfg.enable & analog_out;
    assign sync_out = cfg.enable & sync;

    assign rise = sync & ~sync_d;
    assign fall = ~sync & sync_d;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= 1'b0;
            sync <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            meta <= raw_out;
            sync <= meta;
            sync_d <= sync;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rise_flag <= 1'b0;
            fall_flag <= 1'b0;
        end else begin
            rise_flag <= rise | (rise_flag & ~cfg.clr_rise);
            fall_flag <= fall | (fall_flag & ~cfg.clr_fall);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            latched <= 1'b0;
        end else if (overflow) begin
            latched <= sync;
        end
    end

    assign cfg.rise_flag = rise_flag;
    assign cfg.fall_flag = fall_flag;
    assign cfg.out_state = sync;
    assign cfg.latched_out = latched;
    assign cfg.irq = (rise_flag & cfg.rise_ie)
        | (fall_flag & cfg.fall_ie);
endmodule

/* verilog/dual_comparator_control.sv */
// Added by the designer: the AXI4-Lite register port and the address map.
module dual_comparator_control (
    // System
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // AXI4-Lite write address
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read address
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    // AXI4-Lite read data
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Analog comparator results and counter array overflow
    input wire logic [1:0] ANALOG_OUT,
    input wire logic COUNTER_OVERFLOW,
    // Analog controls
    output logic [1:0] POWER_ON,
    output logic [8:0] POS_ROUTE0,
    output logic [8:0] NEG_ROUTE0,
    output logic [8:0] POS_ROUTE1,
    output logic [8:0] NEG_ROUTE1,
    output logic [3:0] HYST_POS,
    output logic [3:0] HYST_NEG,
    output logic [3:0] RESPONSE_MODE,
    // Pin outputs and interrupt requests
    output logic [1:0] LATCHED_OUTPUT,
    output logic [1:0] RAW_OUTPUT,
    output logic [1:0] CMP_IRQ
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [1:0] enable;
    logic [1:0] hyp0;
    logic [1:0] hyp1;
    logic [1:0] hyn0;
    logic [1:0] hyn1;
    logic [1:0] md0;
    logic [1:0] md1;
    logic [3:0] psel0;
    logic [3:0] psel1;
    logic [3:0] nsel0;
    logic [3:0] nsel1;
    logic [1:0] rie;
    logic [1:0] fie;
    logic [1:0] clr_rise;
    logic [1:0] clr_fall;
    logic [1:0] next_clr_rise;
    logic [1:0] next_clr_fall;

    cmp_cfg_if cfg0 ();
    cmp_cfg_if cfg1 ();

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic do_read;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_word;

    assign AWREADY = ~aw_held & ~BVALID;
    assign WREADY = ~w_held & ~BVALID;
    assign ARREADY = ~RVALID;
    assign do_write = aw_held & w_held & ~BVALID;
    assign do_read = ARVALID & ARREADY;

    function automatic logic hit(input logic [7:0] a);
        hit = (a == cmp_pkg::CTRL0_ADDR) || (a == cmp_pkg::MODE0_ADDR)
            || (a == cmp_pkg::MUX0_ADDR) || (a == cmp_pkg::CTRL1_ADDR)
            || (a == cmp_pkg::MODE1_ADDR) || (a == cmp_pkg::MUX1_ADDR);
    endfunction

    assign wr_hit = hit(aw_addr);
    assign rd_hit = hit(ARADDR);

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (AWVALID && AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= AWADDR;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (WVALID && WREADY) begin
            w_held <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            BVALID <= 1'b0;
            BRESP <= cmp_pkg::AXI_OKAY;
        end else if (do_write) begin
            BVALID <= 1'b1;
            BRESP <= wr_hit ? cmp_pkg::AXI_OKAY : cmp_pkg::AXI_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register writes (only byte lane 0 carries data)
    // ------------------------------------------------------------
    logic wr_lane;
    logic [7:0] wb;
    assign wr_lane = do_write & w_strb[0];
    assign wb = w_data[7:0];

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            enable <= 2'h0;
            hyp0 <= 2'h0;
            hyn0 <= 2'h0;
            hyp1 <= 2'h0;
            hyn1 <= 2'h0;
            md0 <= cmp_pkg::MODE_RESET;
            md1 <= cmp_pkg::MODE_RESET;
            rie <= 2'h0;
            fie <= 2'h0;
            psel0 <= cmp_pkg::MUX_RESET;
            nsel0 <= cmp_pkg::MUX_RESET;
            psel1 <= cmp_pkg::MUX_RESET;
            nsel1 <= cmp_pkg::MUX_RESET;
        end else if (wr_lane) begin
            if (aw_addr == cmp_pkg::CTRL0_ADDR) begin
                enable[0] <= wb[cmp_pkg::EN_BIT];
                hyp0 <= wb[cmp_pkg::HYP_LSB +: 2];
                hyn0 <= wb[cmp_pkg::HYN_LSB +: 2];
            end
            if (aw_addr == cmp_pkg::CTRL1_ADDR) begin
                enable[1] <= wb[cmp_pkg::EN_BIT];
                hyp1 <= wb[cmp_pkg::HYP_LSB +: 2];
                hyn1 <= wb[cmp_pkg::HYN_LSB +: 2];
            end
            if (aw_addr == cmp_pkg::MODE0_ADDR) begin
                rie[0] <= wb[cmp_pkg::RIE_BIT];
                fie[0] <= wb[cmp_pkg::FIE_BIT];
                md0 <= wb[cmp_pkg::MD_LSB +: 2];
            end
            if (aw_addr == cmp_pkg::MODE1_ADDR) begin
                rie[1] <= wb[cmp_pkg::RIE_BIT];
                fie[1] <= wb[cmp_pkg::FIE_BIT];
                md1 <= wb[cmp_pkg::MD_LSB +: 2];
            end
            if (aw_addr == cmp_pkg::MUX0_ADDR) begin
                nsel0 <= wb[cmp_pkg::MXN_LSB +: 4];
                psel0 <= wb[cmp_pkg::MXP_LSB +: 4];
            end
            if (aw_addr == cmp_pkg::MUX1_ADDR) begin
                nsel1 <= wb[cmp_pkg::MXN_LSB +: 4];
                psel1 <= wb[cmp_pkg::MXP_LSB +: 4];
            end
        end
    end

    // Writing 0 to a flag bit clears it; writing 1 leaves it alone
    assign next_clr_rise[0] = wr_lane && aw_addr == cmp_pkg::CTRL0_ADDR
        && !wb[cmp_pkg::RISE_BIT];
    assign next_clr_fall[0] = wr_lane && aw_addr == cmp_pkg::CTRL0_ADDR
        && !wb[cmp_pkg::FALL_BIT];
    assign next_clr_rise[1] = wr_lane && aw_addr == cmp_pkg::CTRL1_ADDR
        && !wb[cmp_pkg::RISE_BIT];
    assign next_clr_fall[1] = wr_lane && aw_addr == cmp_pkg::CTRL1_ADDR
        && !wb[cmp_pkg::FALL_BIT];
    assign clr_rise = next_clr_rise;
    assign clr_fall = next_clr_fall;

    // ------------------------------------------------------------
    // Channel settings
    // ------------------------------------------------------------
    assign cfg0.enable = enable[0];
    assign cfg0.hyst_pos = hyp0;
    assign cfg0.hyst_neg = hyn0;
    assign cfg0.mode = md0;
    assign cfg0.pos_sel = psel0;
    assign cfg0.neg_sel = nsel0;
    assign cfg0.rise_ie = rie[0];
    assign cfg0.fall_ie = fie[0];
    assign cfg0.clr_rise = clr_rise[0];
    assign cfg0.clr_fall = clr_fall[0];
    assign cfg1.enable = enable[1];
    assign cfg1.hyst_pos = hyp1;
    assign cfg1.hyst_neg = hyn1;
    assign cfg1.mode = md1;
    assign cfg1.pos_sel = psel1;
    assign cfg1.neg_sel = nsel1;
    assign cfg1.rise_ie = rie[1];
    assign cfg1.fall_ie = fie[1];
    assign cfg1.clr_rise = clr_rise[1];
    assign cfg1.clr_fall = clr_fall[1];

    cmp_channel u_first_comparator (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .cfg(cfg0),
        .analog_out(ANALOG_OUT[0]),
        .overflow(COUNTER_OVERFLOW),
        .power_on(POWER_ON[0]),
        .pos_route(POS_ROUTE0),
        .neg_route(NEG_ROUTE0),
        .hyst_pos(HYST_POS[1:0]),
        .hyst_neg(HYST_NEG[1:0]),
        .mode(RESPONSE_MODE[1:0]),
        .sync_out(LATCHED_OUTPUT[0]),
        .raw_out(RAW_OUTPUT[0])
    );

    cmp_channel u_second_comparator (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .cfg(cfg1),
        .analog_out(ANALOG_OUT[1]),
        .overflow(COUNTER_OVERFLOW),
        .power_on(POWER_ON[1]),
        .pos_route(POS_ROUTE1),
        .neg_route(NEG_ROUTE1),
        .hyst_pos(HYST_POS[3:2]),
        .hyst_neg(HYST_NEG[3:2]),
        .mode(RESPONSE_MODE[3:2]),
        .sync_out(LATCHED_OUTPUT[1]),
        .raw_out(RAW_OUTPUT[1])
    );

    // ------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------
    assign CMP_IRQ = {cfg1.irq, cfg0.irq};

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    function automatic logic [7:0] ctrl_word(input logic en,
        input logic o, input logic r, input logic f,
        input logic [1:0] hp, input logic [1:0] hn);
        ctrl_word = {en, o, r, f, hp, hn};
    endfunction

    always_comb begin
        rd_word = 32'h00000000;
        unique case (ARADDR)
            cmp_pkg::CTRL0_ADDR: rd_word[7:0] = ctrl_word(enable[0],
                cfg0.out_state, cfg0.rise_flag, cfg0.fall_flag,
                hyp0, hyn0);
            cmp_pkg::CTRL1_ADDR: rd_word[7:0] = ctrl_word(enable[1],
                cfg1.out_state, cfg1.rise_flag, cfg1.fall_flag,
                hyp1, hyn1);
            cmp_pkg::MODE0_ADDR: rd_word[7:0] = {cfg0.latched_out, 1'b0,
                rie[0], fie[0], 2'h0, md0};
            cmp_pkg::MODE1_ADDR: rd_word[7:0] = {cfg1.latched_out, 1'b0,
                rie[1], fie[1], 2'h0, md1};
            cmp_pkg::MUX0_ADDR: rd_word[7:0] = {nsel0, psel0};
            cmp_pkg::MUX1_ADDR: rd_word[7:0] = {nsel1, psel1};
            default: rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= cmp_pkg::AXI_OKAY;
        end else if (do_read) begin
            RVALID <= 1'b1;
            RDATA <= rd_word;
            RRESP <= rd_hit ? cmp_pkg::AXI_OKAY : cmp_pkg::AXI_SLVERR;
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end
endmodule
